// *** core/sac_adc_ctrl.sv ***
// Successive-approximation converter control with AXI4-Lite register access
module sac_adc_ctrl #(
  parameter int unsigned SUBCYC_CLKS = sac_pkg::SUBCYC_CLKS_DEF
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [sac_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [sac_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        comp_high,
  output sac_pkg::sac_analog_t             analog,
  output logic                             conv_irq
);

  sac_pkg::sac_state_t s;
  sac_pkg::sac_state_t next_s;

  logic        wr_fire;
  logic        wr_hit;
  logic [1:0]  wr_sel;
  logic        wr_ctrl;
  logic        rd_hit;
  logic [1:0]  rd_sel;
  logic        start;
  logic        abort;
  logic        finish;
  logic        tick;
  logic [11:0] sar_n;
  logic [15:0] rem_n;
  logic [15:0] mask;
  logic [15:0] window;
  logic [7:0]  wd;
  logic [7:0]  ctrl_rd;

  function automatic logic [11:0] onehot(input logic [3:0] idx);
    onehot = 12'h001 << idx;
  endfunction : onehot

  // Returns {hit, select}; low address bits are ignored
  function automatic logic [2:0] decode(input logic [sac_pkg::ADDR_W-1:0] a);
    case (a[sac_pkg::ADDR_W-1:2])
      sac_pkg::IDX_CONTROL:     decode = {1'b1, sac_pkg::SEL_CONTROL};
      sac_pkg::IDX_MODE:        decode = {1'b1, sac_pkg::SEL_MODE};
      sac_pkg::IDX_RESULT_LOW:  decode = {1'b1, sac_pkg::SEL_RESULT_LOW};
      sac_pkg::IDX_RESULT_HIGH: decode = {1'b1, sac_pkg::SEL_RESULT_HIGH};
      default:                  decode = 3'h0;
    endcase
  endfunction : decode

  // Reserved bits read as zero
  function automatic logic [7:0] reg_read(input sac_pkg::sac_state_t st,
                                          input logic [1:0] sel);
    case (sel)
      sac_pkg::SEL_CONTROL:
        reg_read = {st.chan_sel, 1'b0, st.seq == sac_pkg::SAC_SEQ_RUN,
                    st.conv_done_flag, st.conv_irq_enable};
      sac_pkg::SEL_MODE:
        reg_read = {1'b0, st.resolution_select, 4'h0, st.time_code_mid, st.time_code_low};
      sac_pkg::SEL_RESULT_LOW:
        reg_read = {st.result_low_nibble, 3'h0, st.time_code_top};
      default:
        reg_read = st.result_high;
    endcase
  endfunction : reg_read

  function automatic logic [15:0] total_ticks(input logic res8, input logic [2:0] tc,
                                              input logic dbl);
    logic [15:0] t;
    t = ((res8 ? sac_pkg::CONV_BASE_8 : sac_pkg::CONV_BASE_12) << tc)
        + sac_pkg::CONV_EXTRA;
    total_ticks = dbl ? (t << 1) : t;
  endfunction : total_ticks

  localparam logic [7:0] SUB_LAST = 8'(SUBCYC_CLKS - 1);

  assign {wr_hit, wr_sel} = decode(s.aw_addr);
  assign {rd_hit, rd_sel} = decode(araddr);
  assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
  assign wr_ctrl = wr_fire && wr_hit && s.w_lane0 && (wr_sel == sac_pkg::SEL_CONTROL);
  assign wd      = s.w_data;
  // Software view of control, so checks can see the start bit as read
  assign ctrl_rd = reg_read(s, sac_pkg::SEL_CONTROL);

  always_comb begin
    next_s = s;
    start  = 1'b0;
    abort  = 1'b0;
    finish = 1'b0;
    tick   = 1'b0;
    sar_n  = s.sar;
    rem_n  = s.remain;
    mask   = 16'h0000;
    window = 16'h0000;

    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held  = 1'b1;
      next_s.w_data  = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_hit ? reg_read(s, rd_sel) : sac_pkg::REG_RESET;
      next_s.rresp  = rd_hit ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
    end

    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = wr_hit ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
      if (wr_hit && s.w_lane0) begin
        case (wr_sel)
          sac_pkg::SEL_CONTROL: begin
            next_s.chan_sel        = wd[sac_pkg::CTRL_CHAN_LSB +: 4];
            next_s.conv_irq_enable = wd[sac_pkg::CTRL_IE_BIT];
            // Writing 0 clears the end flag, writing 1 leaves it alone
            if (!wd[sac_pkg::CTRL_DONE_BIT]) begin
              next_s.conv_done_flag = 1'b0;
            end
            if (wd[sac_pkg::CTRL_GO_BIT] && s.seq == sac_pkg::SAC_SEQ_IDLE) begin
              start = 1'b1;
            end
            if (!wd[sac_pkg::CTRL_GO_BIT] && s.seq == sac_pkg::SAC_SEQ_RUN) begin
              abort = 1'b1;
            end
          end
          sac_pkg::SEL_MODE: begin
            next_s.resolution_select = wd[sac_pkg::MODE_RES_BIT];
            next_s.time_code_mid     = wd[sac_pkg::MODE_MID_BIT];
            next_s.time_code_low     = wd[sac_pkg::MODE_LOW_BIT];
            if (s.resolution_select && !wd[sac_pkg::MODE_RES_BIT]) begin
              next_s.need_double = 1'b1;
            end
          end
          sac_pkg::SEL_RESULT_LOW: begin
            next_s.result_low_nibble = wd[sac_pkg::LOW_NIB_LSB +: 4];
            next_s.time_code_top     = wd[sac_pkg::LOW_TOP_BIT];
          end
          default: begin
            next_s.result_high = wd;
          end
        endcase
      end
    end

    case (s.seq)
      sac_pkg::SAC_SEQ_IDLE: begin
        if (start) begin
          next_s.seq        = sac_pkg::SAC_SEQ_RUN;
          next_s.res8_run   = s.resolution_select;
          next_s.remain     = total_ticks(s.resolution_select,
                                          {s.time_code_top, s.time_code_mid, s.time_code_low},
                                          !s.resolution_select && s.need_double);
          next_s.step_shift = {1'b0, s.time_code_top, s.time_code_mid, s.time_code_low}
                              + sac_pkg::STEP_SHIFT_BASE
                              + {3'h0, !s.resolution_select && s.need_double};
          next_s.bit_idx    = sac_pkg::MSB_IDX;
          next_s.sar        = 12'h000;
          next_s.sub_cnt    = 8'h00;
          if (!s.resolution_select) begin
            next_s.need_double = 1'b0;
          end
        end
      end
      sac_pkg::SAC_SEQ_RUN: begin
        if (abort) begin
          // Halted mid-way: results are not touched, the trial code is stale
          next_s.seq = sac_pkg::SAC_SEQ_IDLE;
        end else begin
          tick           = (s.sub_cnt == 8'h00);
          next_s.sub_cnt = (s.sub_cnt == SUB_LAST) ? 8'h00 : s.sub_cnt + 8'h01;
          if (tick) begin
            rem_n         = s.remain - 16'h0001;
            next_s.remain = rem_n;
            mask          = (16'h0001 << s.step_shift) - 16'h0001;
            window        = (s.res8_run ? sac_pkg::BITS_8 : sac_pkg::BITS_12) << s.step_shift;
            // Bits resolve in the tail of the conversion, one per divided step
            if (rem_n < window && (rem_n & mask) == 16'h0000) begin
              if (comp_high) begin
                sar_n = s.sar | onehot(s.bit_idx);
              end
              next_s.sar     = sar_n;
              next_s.bit_idx = s.bit_idx - 4'h1;
            end
            if (rem_n == 16'h0000) begin
              finish                = 1'b1;
              next_s.seq            = sac_pkg::SAC_SEQ_IDLE;
              next_s.conv_done_flag = 1'b1;
              next_s.result_high    = sar_n[11:4];
              if (!s.res8_run) begin
                next_s.result_low_nibble = sar_n[3:0];
              end
            end
          end
        end
      end
      default: begin
        next_s.seq = sac_pkg::SAC_SEQ_IDLE;
      end
    endcase
  end

  // Synchronous reset also stops a conversion in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= sac_pkg::STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign awready = !s.aw_held && !s.bvalid;
  assign wready  = !s.w_held && !s.bvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = {24'h00_0000, s.rdata};

  assign analog.ref_gen_en      = (s.seq == sac_pkg::SAC_SEQ_RUN);
  assign analog.input_selector  = s.chan_sel;
  assign analog.ladder_selector = (s.seq == sac_pkg::SAC_SEQ_RUN)
                                  ? (s.sar | onehot(s.bit_idx)) : 12'h000;
  assign conv_irq = s.conv_irq_enable && s.conv_done_flag;

  // Checking helpers: independent length model of a conversion
  logic [31:0] run_len;
  logic [31:0] exp_ticks;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_len   <= 32'h0000_0000;
      exp_ticks <= 32'h0000_0000;
    end else if (start) begin
      run_len   <= 32'h0000_0000;
      exp_ticks <= ((s.resolution_select ? 32 : 52)
                    * (1 << {s.time_code_top, s.time_code_mid, s.time_code_low}) + 2)
                   * ((!s.resolution_select && s.need_double) ? 2 : 1);
    end else if (s.seq == sac_pkg::SAC_SEQ_RUN) begin
      run_len <= run_len + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_route;
    wr_ctrl |=> analog.input_selector == $past(wd[7:4]);
  endproperty
  a_route: assert property (p_route) else $error("channel code not routed");

  property p_start;
    start |=> analog.ref_gen_en && analog.ladder_selector == 12'h800;
  endproperty
  a_start: assert property (p_start) else $error("start did not begin conversion");

  property p_finish;
    finish |=> !analog.ref_gen_en && s.conv_done_flag && !ctrl_rd[sac_pkg::CTRL_GO_BIT];
  endproperty
  a_finish: assert property (p_finish) else $error("completion effects missing");

  // Halting never sets done; the halting write itself may clear it
  property p_abort;
    abort |=> !analog.ref_gen_en && $stable(s.result_high)
              && s.conv_done_flag == ($past(s.conv_done_flag)
                                      && $past(wd[sac_pkg::CTRL_DONE_BIT]));
  endproperty
  a_abort: assert property (p_abort) else $error("halt did not stop conversion");

  // A control write just after the end may legally withdraw the request
  property p_irq;
    finish && s.conv_irq_enable && !wr_ctrl |=> conv_irq ##1 (conv_irq || $past(wr_ctrl));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised at end");

  property p_res8;
    finish && s.res8_run |=> s.result_high == $past(sar_n[11:4])
                             && s.result_low_nibble == $past(s.result_low_nibble);
  endproperty
  a_res8: assert property (p_res8) else $error("8-bit result placement wrong");

  property p_res12;
    finish && !s.res8_run |=> {s.result_high, s.result_low_nibble} == $past(sar_n);
  endproperty
  a_res12: assert property (p_res12) else $error("12-bit result placement wrong");

  property p_len;
    finish |-> run_len == (exp_ticks - 32'h0000_0001) * SUBCYC_CLKS;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");

  // The end flag only drops through a control write or a reset
  property p_done_hold;
    $fell(s.conv_done_flag) |-> !$past(aresetn)
                                || $past(wr_ctrl && !wd[sac_pkg::CTRL_DONE_BIT]);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("end flag dropped");

  property p_ref_stop;
    $fell(analog.ref_gen_en) |-> !$past(aresetn) || $past(finish || abort);
  endproperty
  a_ref_stop: assert property (p_ref_stop) else $error("reference dropped early");

  // Watched through reset itself, so the default disable is switched off
  property p_reset_stop;
    disable iff (1'b0)
    !aresetn |=> !analog.ref_gen_en && !conv_irq && !bvalid && !rvalid;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("active after reset");

  c_done12: cover property (finish && !s.res8_run);
  c_done8:  cover property (finish && s.res8_run);
  c_abort:  cover property (abort);
  c_double: cover property (start && !s.resolution_select && s.need_double);

endmodule : sac_adc_ctrl

// *** core/sac_pkg.sv ***
// Constants, register map and state types for the converter control block
// Summary of operation
// - Channel codes 0000 to 0100 route analog inputs 0 to 4 to the converter.
// - Writing 1 to the start bit begins a conversion with current settings.
// - The start bit clears itself when the conversion completes.
// - Writing 0 to the start bit halts the conversion; its result is invalid.
// - The end flag is set when a conversion finishes.
// - Interrupt request is raised while interrupt enable and end flag are both 1.
// - Mode bit 6 picks resolution: 0 gives 12-bit, 1 gives 8-bit.
// - 8-bit result goes to the high byte only; low byte left unchanged.
// - 12-bit result: upper 8 bits to high byte, lower 4 to low bits 7..4.
// - Three-bit time code selects division ratio 1/2^code, from 1/1 to 1/128.
// - 12-bit conversion lasts (52/ratio + 2) thirds of an instruction cycle.
// - 8-bit conversion lasts (32/ratio + 2) thirds of an instruction cycle.
// - First 12-bit conversion after reset or 8-to-12 switch takes double time.
// - Reference generator runs exactly while a conversion is in progress.
// - Reset during a conversion clears the start bit and stops the converter.
package sac_pkg;

  localparam int unsigned ADDR_W = 18;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CONTROL     = 16'hfe58;
  localparam logic [15:0] IDX_MODE        = 16'hfe59;
  localparam logic [15:0] IDX_RESULT_LOW  = 16'hfe5a;
  localparam logic [15:0] IDX_RESULT_HIGH = 16'hfe5b;

  localparam logic [1:0] SEL_CONTROL     = 2'h0;
  localparam logic [1:0] SEL_MODE        = 2'h1;
  localparam logic [1:0] SEL_RESULT_LOW  = 2'h2;
  localparam logic [1:0] SEL_RESULT_HIGH = 2'h3;

  // Field positions
  localparam int unsigned CTRL_CHAN_LSB = 4;
  localparam int unsigned CTRL_GO_BIT   = 2;
  localparam int unsigned CTRL_DONE_BIT = 1;
  localparam int unsigned CTRL_IE_BIT   = 0;
  localparam int unsigned MODE_RES_BIT  = 6;
  localparam int unsigned MODE_MID_BIT  = 1;
  localparam int unsigned MODE_LOW_BIT  = 0;
  localparam int unsigned LOW_NIB_LSB   = 4;
  localparam int unsigned LOW_TOP_BIT   = 0;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Conversion timing in thirds of an instruction cycle
  localparam logic [15:0] CONV_BASE_12    = 16'h0034;
  localparam logic [15:0] CONV_BASE_8     = 16'h0020;
  localparam logic [15:0] CONV_EXTRA      = 16'h0002;
  localparam logic [15:0] BITS_12         = 16'h000c;
  localparam logic [15:0] BITS_8          = 16'h0008;
  localparam logic [3:0]  STEP_SHIFT_BASE = 4'h2;
  localparam logic [3:0]  MSB_IDX         = 4'hb;
  localparam int unsigned SUBCYC_CLKS_DEF = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    SAC_SEQ_IDLE = 1'b0,
    SAC_SEQ_RUN  = 1'b1
  } sac_seq_t;

  typedef struct packed {
    logic                 ref_gen_en;
    logic [3:0]           input_selector;
    logic [11:0]          ladder_selector;
  } sac_analog_t;

  typedef struct packed {
    logic [3:0]           chan_sel;
    logic                 conv_done_flag;
    logic                 conv_irq_enable;
    logic                 resolution_select;
    logic                 time_code_mid;
    logic                 time_code_low;
    logic                 time_code_top;
    logic [3:0]           result_low_nibble;
    logic [7:0]           result_high;
    logic                 need_double;
    sac_seq_t             seq;
    logic                 res8_run;
    logic [3:0]           step_shift;
    logic [15:0]          remain;
    logic [3:0]           bit_idx;
    logic [11:0]          sar;
    logic [7:0]           sub_cnt;
    logic                 aw_held;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_held;
    logic [7:0]           w_data;
    logic                 w_lane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
  } sac_state_t;

  // need_double starts set so the first 12-bit conversion runs long
  localparam sac_state_t STATE_RST = '{need_double: 1'b1, seq: SAC_SEQ_IDLE, default: '0};

endpackage : sac_pkg

// *** tb/sac_comp_model.sv ***
// Comparator, ladder and input selector model facing the converter control
module sac_comp_model (
  input  wire logic                 aclk,
  input  wire sac_pkg::sac_analog_t analog,
  output logic                      comp_high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] vin [5];
  logic        wander;
  initial begin
    vin = '{12'h5a3, 12'hfff, 12'h000, 12'h801, 12'h3c7};
    wander = 1'b0;
  end
  // Output means nothing without the reference, so it keeps changing
  always @(posedge aclk) begin
    wander <= ~wander;
  end
  assign comp_high = (analog.ref_gen_en && analog.input_selector < 4'h5) ?
                     (vin[analog.input_selector] >= analog.ladder_selector) : wander;
endmodule : sac_comp_model

// *** tb/tb.sv ***
// Self-checking bench for the converter control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CTL = sac_pkg::IDX_CONTROL;
  localparam logic [15:0] MOD = sac_pkg::IDX_MODE;
  localparam logic [15:0] RLO = sac_pkg::IDX_RESULT_LOW;
  localparam logic [15:0] RHI = sac_pkg::IDX_RESULT_HIGH;
  localparam logic [1:0]  OK  = sac_pkg::RESP_OKAY;
  logic                        aclk = 1'b0;
  logic                        aresetn = 1'b0;
  logic [sac_pkg::ADDR_W-1:0]  awaddr = '0;
  logic [sac_pkg::ADDR_W-1:0]  araddr = '0;
  logic [31:0]                 wdata = '0;
  logic [3:0]                  wstrb = 4'h1;
  logic                        awvalid = 1'b0;
  logic                        wvalid = 1'b0;
  logic                        bready = 1'b0;
  logic                        arvalid = 1'b0;
  logic                        rready = 1'b0;
  logic                        awready, wready, bvalid, arready, rvalid;
  logic [1:0]                  bresp, rresp;
  logic [31:0]                 rdata;
  logic                        comp_high, conv_irq;
  sac_pkg::sac_analog_t        analog;
  int                          err_count = 0;
  int                          comparisons = 0;
  int                          cnt = 0;
  int                          last_len = 0;
  int                          runs = 0;

  always #2 aclk = ~aclk;

  sac_adc_ctrl #(.SUBCYC_CLKS(1)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .comp_high(comp_high), .analog(analog), .conv_irq(conv_irq)
  );

  sac_comp_model u_model (.aclk(aclk), .analog(analog), .comp_high(comp_high));

  // Length of each reference-on stretch, in clock cycles
  always @(posedge aclk) begin
    if (analog.ref_gen_en === 1'b1) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      last_len <= cnt;
      cnt <= 0;
      runs <= runs + 1;
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tmo(input string what);
    err_count++;
    $display("[FAIL] %0t timeout in %s", $time, what);
    end_of_test();
  endtask : tmo

  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic hs_aw, hs_w, hs_b;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      hs_aw = awvalid && awready;
      hs_w = wvalid && wready;
      hs_b = bvalid && bready;
      rsp = bresp;
      @(posedge aclk);
      if (hs_aw) awvalid <= 1'b0;
      if (hs_w) wvalid <= 1'b0;
      n++;
    end while (!hs_b && n < 64);
    bready <= 1'b0;
    if (!hs_b) tmo("write");
    chk(rsp, er, "write response");
  endtask : axi_wr

  task automatic axi_rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic hs_ar, hs_r;
    logic [31:0] d;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      hs_ar = arvalid && arready;
      hs_r = rvalid && rready;
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (hs_ar) arvalid <= 1'b0;
      n++;
    end while (!hs_r && n < 64);
    rready <= 1'b0;
    if (!hs_r) tmo("read");
    chk(d, {24'h00_0000, ed}, "read data");
    chk(rsp, er, "read response");
  endtask : axi_rd

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] ed);
    axi_rd(idx, ed, OK);
  endtask : rd_chk

  task automatic run_conv(input logic [7:0] ctl, input int t_exp);
    int r0, n;
    r0 = runs;
    axi_wr(CTL, ctl, OK);
    n = 0;
    while (runs == r0 && n < 20000) begin
      @(negedge aclk);
      n++;
    end
    if (runs == r0) tmo("conversion");
    chk(last_len, t_exp, "conversion length");
  endtask : run_conv

  task automatic t_reset();
    rd_chk(CTL, 8'h00);
    rd_chk(MOD, 8'h00);
    rd_chk(RLO, 8'h00);
    rd_chk(RHI, 8'h00);
    axi_rd(16'hfe5c, 8'h00, sac_pkg::RESP_SLVERR);
    axi_wr(16'hfe5c, 8'h5a, sac_pkg::RESP_SLVERR);
  endtask : t_reset

  task automatic t_twelve();
    run_conv(8'h04, 108);
    rd_chk(CTL, 8'h02);
    rd_chk(RHI, 8'h5a);
    rd_chk(RLO, 8'h30);
    run_conv(8'h34, 54);
    rd_chk(RHI, 8'h80);
    rd_chk(RLO, 8'h10);
  endtask : t_twelve

  task automatic t_channels();
    logic [7:0] hi [5];
    hi = '{8'h5a, 8'hff, 8'h00, 8'h80, 8'h3c};
    axi_wr(MOD, 8'h40, OK);
    for (int c = 0; c < 5; c++) begin
      run_conv({c[3:0], 4'h5}, 34);
      rd_chk(RHI, hi[c]);
      chk(conv_irq, 1, "interrupt raised");
      axi_wr(CTL, {c[3:0], 4'h2}, OK);
      rd_chk(CTL, {c[3:0], 4'h2});
      chk(conv_irq, 0, "interrupt masked");
      axi_wr(CTL, {c[3:0], 4'h1}, OK);
      chk(conv_irq, 0, "interrupt cleared");
    end
  endtask : t_channels

  task automatic t_codes();
    for (int c = 0; c < 8; c++) begin
      axi_wr(MOD, {2'h1, 4'h0, c[1:0]}, OK);
      axi_wr(RLO, {4'ha, 3'h0, c[2]}, OK);
      run_conv(8'h44, (32 << c) + 2);
      rd_chk(RLO, {4'ha, 3'h0, c[2]});
      rd_chk(RHI, 8'h3c);
    end
  endtask : t_codes

  task automatic t_back12();
    axi_wr(RLO, 8'h00, OK);
    axi_wr(MOD, 8'h00, OK);
    run_conv(8'h14, 108);
    rd_chk(RHI, 8'hff);
    rd_chk(RLO, 8'hf0);
  endtask : t_back12

  task automatic t_abort();
    axi_wr(MOD, 8'h43, OK);
    axi_wr(RLO, 8'h01, OK);
    axi_wr(RHI, 8'h77, OK);
    axi_wr(CTL, 8'h04, OK);
    repeat (20) @(posedge aclk);
    axi_wr(CTL, 8'h00, OK);
    repeat (2) @(negedge aclk);
    chk(analog.ref_gen_en, 0, "reference after halt");
    rd_chk(CTL, 8'h00);
    rd_chk(RHI, 8'h77);
  endtask : t_abort

  task automatic t_reset_mid();
    axi_wr(CTL, 8'h04, OK);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(analog.ref_gen_en, 0, "reference after reset");
    rd_chk(CTL, 8'h00);
    rd_chk(MOD, 8'h00);
  endtask : t_reset_mid

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_twelve();
    t_channels();
    t_codes();
    t_back12();
    t_abort();
    t_reset_mid();
    end_of_test();
  end
endmodule : tb
